// >>> verilog/sei_consts.svh
// Named constants for the sideband error and interrupt signalling block.
`ifndef SEI_CONSTS_SVH
`define SEI_CONSTS_SVH
`define SEI_NPORT        4
`define SEI_NDOWN        3
`define SEI_NUNC         32
`define SEI_UIE_BIT      22
`define SEI_DEB_MS       10
`define SEI_CLK_KHZ      250000
`define SEI_DEB_CYCLES   (`SEI_DEB_MS * `SEI_CLK_KHZ)
`define SEI_DEB_W        22
`define SEI_US_PER_MS    1000
`define SEI_TICK_CYCLES  (`SEI_CLK_KHZ / `SEI_US_PER_MS)
`define SEI_DEB_TICKS    (`SEI_DEB_MS * `SEI_US_PER_MS)
`define SEI_SRC_PME      0
`define SEI_SRC_HP       1
`define SEI_SRC_GPI      2
`define SEI_NSRC         3
`endif

// >>> verilog/sei_pkg.sv
// Types shared by the sideband error and interrupt signalling block.
package sei_pkg;
  typedef struct packed {
    logic [31:0] severity;
    logic [31:0] mask;
    logic        fatalRptEn;
    logic        serrEn;
  } sei_errcfg_t;

  typedef struct packed {
    logic intxDisable;
    logic msiEnable;
    logic pinEnHp;
    logic pinEnOther;
  } sei_intcfg_t;

  typedef struct packed {
    logic pdcEnable;
    logic hpIntEnable;
  } sei_slotcfg_t;

  typedef enum logic [2:0] {
    SEI_MECH_NONE = 3'h1,
    SEI_MECH_MSG  = 3'h2,
    SEI_MECH_PIN  = 3'h4
  } sei_mech_t;
endpackage

// >>> verilog/sei_debounce.sv
// Debouncer for one active-low slot presence input.
`timescale 1ns/1ns
`default_nettype none
`include "sei_consts.svh"
module sei_debounce (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic rawIn,
  input  wire logic debounceTick,
  output logic      stable,
  output logic      changed
);
  logic [`SEI_DEB_W-1:0] count;
  logic [`SEI_DEB_W-1:0] next_count;
  logic                  next_stable;
  logic                  next_changed;

  // A new level is accepted only after it held for the whole window.
  always_comb begin
    next_count   = count;
    next_stable  = stable;
    next_changed = 1'b0;
    if (rawIn == stable) begin
      next_count = '0;
    end else if (debounceTick) begin
      next_count = count + `SEI_DEB_W'(1);
      if (next_count == `SEI_DEB_W'(`SEI_DEB_TICKS)) begin
        next_stable  = rawIn;
        next_changed = 1'b1;
        next_count   = '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count   <= '0;
      stable  <= 1'b1;
      changed <= 1'b0;
    end else begin
      count   <= next_count;
      stable  <= next_stable;
      changed <= next_changed;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sei_mech_sel.sv
// Selects the single interrupt signalling mechanism of one port.
`timescale 1ns/1ns
`default_nettype none
module sei_mech_sel (
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire sei_pkg::sei_intcfg_t cfg,
  output var  sei_pkg::sei_mech_t   mech
);
  import sei_pkg::*;
  sei_mech_t next_mech;

  // MSI wins; with interrupt disable clear, a pin enable picks the pin.
  always_comb begin
    if (cfg.msiEnable) begin
      next_mech = SEI_MECH_MSG;
    end else if (cfg.intxDisable) begin
      next_mech = SEI_MECH_NONE;
    end else if (cfg.pinEnHp || cfg.pinEnOther) begin
      next_mech = SEI_MECH_PIN;
    end else begin
      next_mech = SEI_MECH_MSG;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mech <= SEI_MECH_NONE;
    end else begin
      mech <= next_mech;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sei_sideband.sv
// Fatal error pin, presence change latching and legacy interrupt pin.
// How it works
// - Fatal pin low exactly when a fatal error message would be sent.
// - Standard error counts only if severity is fatal and unmasked.
// - Also needs fatal reporting enable or SERR enable of that port.
// - RAM ECC error sets port 0 internal error status; qualifies likewise.
// - Any debounced presence change sets the presence changed status bit.
// - Presence input debounced inside; outside holds it 10 ms per change.
// - Legacy pin only with interrupt disable clear and MSI enable clear.
// - Legacy pin also needs the per-source pin output enable bits set.
// - Each port uses at most one mechanism, message (also with MSI) or pin; none with interrupt disable set and MSI clear.
// - Legacy pin low while any unmasked power, hot plug or GPI event.
`timescale 1ns/1ns
`default_nettype none
`include "sei_consts.svh"
module sei_sideband (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic [`SEI_NPORT-1:0][31:0]   uncErrEvent,
  input  wire logic [`SEI_NPORT-1:0][31:0]   uncErrClear,
  input  wire sei_pkg::sei_errcfg_t [`SEI_NPORT-1:0] errCfg,
  input  wire logic                          ramEccErr,
  input  wire logic [`SEI_NDOWN-1:0]         slot_presence_in_n,
  input  wire sei_pkg::sei_slotcfg_t [`SEI_NDOWN-1:0] slotCfg,
  input  wire logic [`SEI_NDOWN-1:0]         pdcClear,
  input  wire sei_pkg::sei_intcfg_t [`SEI_NPORT-1:0] intCfg,
  input  wire logic [`SEI_NPORT-1:0]         pmeEvent,
  input  wire logic [`SEI_NPORT-1:0]         gpiEvent,
  input  wire logic [`SEI_NPORT-1:0]         srcClear,
  output logic                               fatalErrOutN,
  output logic                               legacy_interrupt_out_n,
  output logic                               legacyIntOe,
  output logic [`SEI_NPORT-1:0][31:0]        uncErrStatus,
  output logic [`SEI_NDOWN-1:0]              presenceState,
  output logic [`SEI_NDOWN-1:0]              pdcStatus,
  output logic [`SEI_NPORT-1:0]              msgIntReq
);
  import sei_pkg::*;

  // Three-bit source pending set: power event, hot plug, GPI.
  logic [`SEI_NPORT-1:0][`SEI_NSRC-1:0] pend;
  logic [`SEI_NPORT-1:0][`SEI_NSRC-1:0] next_pend;
  logic [`SEI_NPORT-1:0][31:0]          next_uncErrStatus;
  logic [`SEI_NDOWN-1:0]                next_pdcStatus;
  logic [`SEI_NDOWN-1:0]                debChanged;
  logic [`SEI_NDOWN-1:0]                debStable;
  logic [`SEI_NPORT-1:0]                hpSet;
  logic [`SEI_NPORT-1:0]                pinReq;
  logic [`SEI_NPORT-1:0]                next_msgIntReq;
  logic [`SEI_NPORT-1:0]                portFatal;
  sei_mech_t [`SEI_NPORT-1:0]           mech;
  logic                                 next_fatalErrOutN;
  logic                                 next_legacyN;
  logic [15:0]                          msDiv;
  logic [15:0]                          next_msDiv;
  logic                                 msTick;

  // Fatal qualification of one port, shared by the pin and assertions.
  function automatic logic fatal_qual(input logic [31:0] st,
                                      input sei_errcfg_t c);
    fatal_qual = |(st & c.severity & ~c.mask) &&
                 (c.fatalRptEn || c.serrEn);
  endfunction

  // Divider giving a one-cycle tick every microsecond for the debouncer.
  always_comb begin
    msTick     = (msDiv == 16'(`SEI_TICK_CYCLES - 1));
    next_msDiv = msTick ? 16'h0000 : msDiv + 16'h0001;
  end

  generate
    for (genvar d = 0; d < `SEI_NDOWN; d++) begin : g_slot
      sei_debounce u_deb (
        .mclk         (mclk),
        .resetn       (resetn),
        .rawIn        (slot_presence_in_n[d]),
        .debounceTick (msTick),
        .stable       (debStable[d]),
        .changed      (debChanged[d])
      );
    end
    for (genvar p = 0; p < `SEI_NPORT; p++) begin : g_mech
      sei_mech_sel u_sel (
        .mclk   (mclk),
        .resetn (resetn),
        .cfg    (intCfg[p]),
        .mech   (mech[p])
      );
    end
  endgenerate

  always_comb begin
    next_uncErrStatus = uncErrStatus;
    next_pdcStatus    = pdcStatus;
    hpSet             = '0;
    for (int p = 0; p < `SEI_NPORT; p++) begin
      // Set wins over a clear in the same cycle.
      next_uncErrStatus[p] = (uncErrStatus[p] & ~uncErrClear[p])
                             | uncErrEvent[p];
    end
    next_uncErrStatus[0][`SEI_UIE_BIT] =
      next_uncErrStatus[0][`SEI_UIE_BIT] | ramEccErr;
    for (int d = 0; d < `SEI_NDOWN; d++) begin
      next_pdcStatus[d] = (pdcStatus[d] & ~pdcClear[d])
                          | debChanged[d];
      // Downstream port d+1 hot plug source is the latched change bit.
      hpSet[d+1] = pdcStatus[d] && slotCfg[d].pdcEnable
                   && slotCfg[d].hpIntEnable;
    end
  end

  always_comb begin
    next_fatalErrOutN = 1'b1;
    next_legacyN      = 1'b1;
    for (int p = 0; p < `SEI_NPORT; p++) begin
      portFatal[p] = fatal_qual(uncErrStatus[p], errCfg[p]);
      if (portFatal[p]) begin
        next_fatalErrOutN = 1'b0;
      end
      next_pend[p] = pend[p] & ~{`SEI_NSRC{srcClear[p]}};
      next_pend[p][`SEI_SRC_PME] = next_pend[p][`SEI_SRC_PME] | pmeEvent[p];
      next_pend[p][`SEI_SRC_GPI] = next_pend[p][`SEI_SRC_GPI] | gpiEvent[p];
      next_pend[p][`SEI_SRC_HP]  = hpSet[p];
      pinReq[p] = (pend[p][`SEI_SRC_HP] && intCfg[p].pinEnHp) ||
                  ((pend[p][`SEI_SRC_PME] || pend[p][`SEI_SRC_GPI])
                   && intCfg[p].pinEnOther);
      if (mech[p] == SEI_MECH_PIN && pinReq[p]) begin
        next_legacyN = 1'b0;
      end
      next_msgIntReq[p] = (mech[p] == SEI_MECH_MSG) && (|pend[p]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      msDiv                  <= 16'h0000;
      uncErrStatus           <= '0;
      pdcStatus              <= '0;
      pend                   <= '0;
      fatalErrOutN           <= 1'b1;
      legacy_interrupt_out_n <= 1'b1;
      legacyIntOe            <= 1'b0;
      presenceState          <= '1;
      msgIntReq              <= '0;
    end else begin
      msDiv                  <= next_msDiv;
      uncErrStatus           <= next_uncErrStatus;
      pdcStatus              <= next_pdcStatus;
      pend                   <= next_pend;
      fatalErrOutN           <= next_fatalErrOutN;
      legacy_interrupt_out_n <= next_legacyN;
      legacyIntOe            <= ~next_legacyN;
      presenceState          <= debStable;
      msgIntReq              <= next_msgIntReq;
    end
  end

  fatal_follow_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (|portFatal) |=> !fatalErrOutN)
    else $error("fatal pin not asserted for a qualified error");
  fatal_release_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !(|portFatal) |=> fatalErrOutN)
    else $error("fatal pin asserted without a qualified error");
  fatal_enable_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!errCfg[0].fatalRptEn && !errCfg[0].serrEn && !(|portFatal[3:1]))
    |=> fatalErrOutN)
    else $error("fatal pin asserted while reporting disabled");
  ecc_latch_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ramEccErr |=> uncErrStatus[0][`SEI_UIE_BIT])
    else $error("ram ecc error not recorded");
  ecc_fatal_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (uncErrStatus[0][`SEI_UIE_BIT] && errCfg[0].severity[`SEI_UIE_BIT] &&
     !errCfg[0].mask[`SEI_UIE_BIT] &&
     (errCfg[0].fatalRptEn || errCfg[0].serrEn))
    |=> !fatalErrOutN)
    else $error("fatal ram ecc error left the fatal pin high");
  pdc_set_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    debChanged[0] |=> pdcStatus[0])
    else $error("presence change not latched");
  hp_gate_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !slotCfg[0].hpIntEnable |=> !pend[1][`SEI_SRC_HP])
    else $error("hot plug pending with interrupt enable clear");
  pin_msi_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (mech[0] != SEI_MECH_PIN && mech[1] != SEI_MECH_PIN &&
     mech[2] != SEI_MECH_PIN && mech[3] != SEI_MECH_PIN)
    |=> legacy_interrupt_out_n)
    else $error("legacy pin asserted outside pin mode");
  // The message request is registered from the previous cycle's mechanism.
  one_mech_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !(msgIntReq[0] && $past(mech[0]) == SEI_MECH_PIN))
    else $error("two mechanisms active on one port");
  pin_oe_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    legacyIntOe == !legacy_interrupt_out_n)
    else $error("legacy pin enable and level disagree");
  legacy_idle_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !(|pinReq) |=> legacy_interrupt_out_n)
    else $error("legacy pin held low with no pin request");

  // Per-port checks of qualification, mechanism choice and pending sources.
  generate
    for (genvar p = 0; p < `SEI_NPORT; p++) begin : g_port_chk
      port_fatal_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        portFatal[p] |=> !fatalErrOutN)
        else $error("qualified port error left the fatal pin high");
      status_set_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (|uncErrEvent[p]) |=> ((uncErrStatus[p] & $past(uncErrEvent[p]))
                               == $past(uncErrEvent[p])))
        else $error("error event not recorded in status");
      pin_gate_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (intCfg[p].msiEnable || intCfg[p].intxDisable)
        |=> mech[p] != SEI_MECH_PIN)
        else $error("pin mechanism chosen while disabled");
      pin_src_gate_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        !(intCfg[p].pinEnHp || intCfg[p].pinEnOther)
        |=> mech[p] != SEI_MECH_PIN)
        else $error("pin mechanism chosen with no pin enable");
      msi_sel_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        intCfg[p].msiEnable |=> mech[p] == SEI_MECH_MSG)
        else $error("message mechanism not chosen with MSI on");
      msg_excl_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        !(msgIntReq[p] && $past(mech[p]) == SEI_MECH_PIN))
        else $error("message request raised in pin mode");
      pme_pend_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        pmeEvent[p] |=> pend[p][`SEI_SRC_PME])
        else $error("power event not held pending");
      gpi_pend_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        gpiEvent[p] |=> pend[p][`SEI_SRC_GPI])
        else $error("input event not held pending");
      pin_low_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (mech[p] == SEI_MECH_PIN && pinReq[p]) |=> !legacy_interrupt_out_n)
        else $error("pin request did not pull the legacy pin low");
      pend_hold_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (pend[p][`SEI_SRC_PME] && !srcClear[p]) |=> pend[p][`SEI_SRC_PME])
        else $error("pending power event lost without a clear");
      pend_clear_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (srcClear[p] && !pmeEvent[p] && !gpiEvent[p])
        |=> (!pend[p][`SEI_SRC_PME] && !pend[p][`SEI_SRC_GPI]))
        else $error("pending source survived its clear");
    end
  endgenerate

  // Per-slot checks of presence latching and hot plug gating.
  generate
    for (genvar d = 0; d < `SEI_NDOWN; d++) begin : g_slot_chk
      slot_pdc_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        debChanged[d] |=> pdcStatus[d])
        else $error("slot presence change not latched");
      presence_follow_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> presenceState[d] == $past(debStable[d]))
        else $error("presence state does not follow debounced level");
      hp_level_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (pdcStatus[d] && slotCfg[d].pdcEnable && slotCfg[d].hpIntEnable)
        |=> pend[d+1][`SEI_SRC_HP])
        else $error("enabled presence change not pending");
      hp_mask_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        !slotCfg[d].pdcEnable |=> !pend[d+1][`SEI_SRC_HP])
        else $error("hot plug pending with change enable clear");
      pdc_hold_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (pdcStatus[d] && !pdcClear[d]) |=> pdcStatus[d])
        else $error("presence changed bit lost without a clear");
      pdc_clear_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (pdcClear[d] && !debChanged[d]) |=> !pdcStatus[d])
        else $error("presence changed bit survived its clear");
    end
  endgenerate
endmodule
`default_nettype wire

// >>> tb/sei_host_model.sv
// Host side model: slot presence pins and the pulled-up interrupt line.
`timescale 1ns/1ns
`default_nettype none
module sei_host_model (
  input  wire logic  mclk,
  input  wire logic  legacyPinN,
  input  wire logic  legacyOe,
  output logic [2:0] presenceN,
  output logic       intLineN
);
  // The line has a pull-up, so it reads high whenever nobody drives it.
  assign intLineN = legacyOe ? legacyPinN : 1'b1;
  initial presenceN = 3'h7;
  // A bounce far shorter than the settle time the slot must keep.
  task automatic bounce(input int slot, input int cycles);
    @(posedge mclk);
    presenceN[slot] <= 1'b0;
    repeat (cycles) @(posedge mclk);
    presenceN[slot] <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench of the sideband error and interrupt block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sei_pkg::*;
  logic             mclk, resetn, ramEccErr, fatalN, legN, oe, intLineN;
  logic [3:0][31:0] uncErrEvent, uncErrClear, uncErrStatus;
  sei_errcfg_t [3:0]  errCfg;
  sei_slotcfg_t [2:0] slotCfg;
  sei_intcfg_t [3:0]  intCfg;
  logic [2:0]       presN, pdcClear, presenceState, pdcStatus;
  logic [3:0]       pmeEvent, gpiEvent, srcClear, msgIntReq;
  int               n_errors = 0;
  int               total_checks = 0;
  // Fatal cases: severity, mask, report enable, SERR enable, pin low.
  logic [4:0]       fc [5] = '{5'h15, 5'h13, 5'h06, 5'h1E, 5'h10};
  // Interrupt cases: disable, MSI, pin enables hp/other, pin low, message.
  logic [5:0]       ic [5] = '{6'h0E, 6'h1D, 6'h01, 6'h08, 6'h2C};

  sei_sideband sei_sideband_inst (.mclk(mclk), .resetn(resetn),
    .uncErrEvent(uncErrEvent), .uncErrClear(uncErrClear), .errCfg(errCfg),
    .ramEccErr(ramEccErr), .slot_presence_in_n(presN), .slotCfg(slotCfg),
    .pdcClear(pdcClear), .intCfg(intCfg), .pmeEvent(pmeEvent),
    .gpiEvent(gpiEvent), .srcClear(srcClear), .fatalErrOutN(fatalN),
    .legacy_interrupt_out_n(legN), .legacyIntOe(oe),
    .uncErrStatus(uncErrStatus), .presenceState(presenceState),
    .pdcStatus(pdcStatus), .msgIntReq(msgIntReq));
  sei_host_model sei_host_model_inst (.mclk(mclk), .legacyPinN(legN),
    .legacyOe(oe), .presenceN(presN), .intLineN(intLineN));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse_err(input int p, input int b, input logic clr);
    @(posedge mclk);
    if (clr) uncErrClear[p][b] <= 1'b1;
    else uncErrEvent[p][b] <= 1'b1;
    @(posedge mclk);
    uncErrClear <= '0;
    uncErrEvent <= '0;
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("[FAIL] %0t run did not finish in time", $time);
    test_done;
  end

  initial begin
    resetn = 1'b0;
    ramEccErr = 1'b0;
    uncErrEvent = '0;
    uncErrClear = '0;
    errCfg = '0;
    slotCfg = '1;
    pdcClear = '0;
    intCfg = '0;
    pmeEvent = '0;
    gpiEvent = '0;
    srcClear = '0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    tick(1);
    chk1(fatalN, 1'b1);
    chk1(intLineN, 1'b1);
    chk32({29'h0, presenceState}, 32'h7);
    // A short bounce with hot plug interrupts enabled must leave no trace.
    sei_host_model_inst.bounce(0, 2000);
    tick(50);
    chk32({29'h0, pdcStatus}, 32'h0);
    chk32({29'h0, presenceState}, 32'h7);
    chk1(intLineN, 1'b1);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      errCfg[2].severity[4] <= fc[i][4];
      errCfg[2].mask[4] <= fc[i][3];
      errCfg[2].fatalRptEn <= fc[i][2];
      errCfg[2].serrEn <= fc[i][1];
      pulse_err(2, 4, 1'b0);
      tick(3);
      chk32(uncErrStatus[2], 32'h0000_0010);
      chk1(fatalN, ~fc[i][0]);
      pulse_err(2, 4, 1'b1);
      tick(3);
      chk1(fatalN, 1'b1);
    end
    @(posedge mclk);
    errCfg[0].severity[22] <= 1'b1;
    errCfg[0].fatalRptEn <= 1'b1;
    ramEccErr <= 1'b1;
    @(posedge mclk);
    ramEccErr <= 1'b0;
    tick(3);
    chk32(uncErrStatus[0], 32'h0040_0000);
    chk1(fatalN, 1'b0);
    @(posedge mclk);
    errCfg[0].mask[22] <= 1'b1;
    tick(3);
    chk1(fatalN, 1'b1);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      intCfg[1] <= '{ic[i][5], ic[i][4], ic[i][3], ic[i][2]};
      if (i == 1) gpiEvent[1] <= 1'b1;
      else pmeEvent[1] <= 1'b1;
      @(posedge mclk);
      pmeEvent <= '0;
      gpiEvent <= '0;
      tick(4);
      chk1(intLineN, ~ic[i][1]);
      chk1(msgIntReq[1], ic[i][0]);
      @(posedge mclk);
      srcClear[1] <= 1'b1;
      @(posedge mclk);
      srcClear[1] <= 1'b0;
      tick(4);
      chk1(intLineN, 1'b1);
      chk1(msgIntReq[1], 1'b0);
    end
    test_done;
  end
endmodule
`default_nettype wire
